// ---- design/gpio_pkg.sv ----
/*
  Constants for the dual-port pin controller: register offsets, bit
  positions, pin indices and reset values.
  Assumes a 32-bit AXI4-Lite register bus, one aligned word a register.
*/
package gpio_pkg;

  // ==========================================================
  // Pin map
  localparam int PA_PINS = 8;
  localparam int PB_PINS = 6;
  localparam int PIN_COUNT = 14;
  localparam int PIN_PA1 = 1;
  localparam int PIN_PA3 = 3;
  localparam int PIN_PA4 = 4;
  localparam int PIN_PA5 = 5;
  localparam int PIN_PA6 = 6;
  localparam int PIN_PA7 = 7;
  localparam int PIN_PB0 = 8;
  localparam int PIN_PB1 = 9;
  localparam int PIN_PB2 = 10;
  localparam int PIN_PB3 = 11;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_DATA_A = 8'h00;
  localparam logic [7:0] OFS_DATA_B = 8'h04;
  localparam logic [7:0] OFS_DIR_A = 8'h08;
  localparam logic [7:0] OFS_DIR_B = 8'h0C;
  localparam logic [7:0] OFS_PH_A = 8'h10;
  localparam logic [7:0] OFS_PH_B = 8'h14;
  localparam logic [7:0] OFS_PL_SHARED = 8'h18;
  localparam logic [7:0] OFS_OD_B = 8'h1C;
  localparam logic [7:0] OFS_POWER = 8'h20;
  localparam logic [7:0] OFS_CHG_A = 8'h24;
  localparam logic [7:0] OFS_CHG_B = 8'h28;
  localparam logic [7:0] OFS_IRQ_FLAG = 8'h2C;
  localparam logic [7:0] OFS_IRQ_EN = 8'h30;
  localparam logic [7:0] OFS_PROC = 8'h34;
  localparam logic [7:0] OFS_EDGE = 8'h38;
  localparam logic [7:0] OFS_IR = 8'h3C;
  localparam logic [7:0] OFS_READ_TYPE = 8'h40;

  // ==========================================================
  // Field positions
  localparam int PWR_PA5_PH_BIT = 4;
  localparam int PA5_PL_BIT = 5;
  localparam int FLAG_CHG_BIT = 1;
  localparam int IE_CHG_BIT = 1;
  localparam int GIE_BIT = 7;
  localparam int EXT0_SEL_BIT = 4;
  localparam int EXT1_SEL_BIT = 5;
  localparam int IR_EN_BIT = 0;
  localparam int EDGE0_LSB = 0;
  localparam int EDGE1_LSB = 2;

  // Edge choice per external interrupt, 2 bits each
  localparam logic [1:0] EDGE_RISING = 2'h0;
  localparam logic [1:0] EDGE_FALLING = 2'h1;

  // ==========================================================
  // Reset values and bus answers
  localparam logic [7:0] DIR_A_RESET = 8'hFF;
  localparam logic [5:0] DIR_B_RESET = 6'h3F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] SETTLE_DONE = 2'h3;

endpackage

// ---- design/sync_bits.sv ----
/*
  Two-flop synchroniser for a vector of pad levels.
  Assumes each bit is an independent level; no bus coherency.
*/
`timescale 1ns/10ps
`default_nettype none

module sync_bits #(
  parameter int WIDTH = 14
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] dIn,
  output logic [WIDTH-1:0] qOut
);

  // ==========================================================
  // Elaboration check
  if (WIDTH < 1) begin : g_chk
    $error("sync_bits WIDTH must be positive");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // First stage feeds only the second one
  always_comb begin
    next_s = s;
    next_s.stage1 = dIn;
    next_s.stage2 = s.stage1;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign qOut = s.stage2;

endmodule

`default_nettype wire

// ---- design/dual_port_io.sv ----
/*
  Pin controller for an 8-pin port A and a 6-pin port B: direction,
  pulls, open-drain, level-change flag, two external edge interrupts,
  infrared pad choice and shared-function output muxing.
  Assumes pads resolve padOut/padOe/pulls outside, straps are static,
  and function sources (PWM, buzzer, comparator) share sys_clk.
*/
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module dual_port_io import gpio_pkg::*; #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  // AXI4-Lite slave
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Pads, bits 7:0 port A, 13:8 port B
  input wire logic [PIN_COUNT-1:0] padIn,
  output logic [PIN_COUNT-1:0] padOut,
  output logic [PIN_COUNT-1:0] padOe,
  output logic [PIN_COUNT-1:0] padPullUp,
  output logic [PIN_COUNT-1:0] padPullDown,
  // Configuration straps
  input wire logic cfgIrLargeCurrent,
  input wire logic cfgExtReset,
  input wire logic cfgCrystal,
  input wire logic cfgClockOut,
  // Shared function sources
  input wire logic instrClk,
  input wire logic irCarrier,
  input wire logic cmpOut,
  input wire logic comparatorOutEnable,
  input wire logic pwmOne,
  input wire logic pwmOneOutEnable,
  input wire logic buzzerOne,
  input wire logic buzzerOneEnable,
  input wire logic pwmTwo,
  input wire logic pwmTwoOutEnable,
  input wire logic buzzerTwo,
  input wire logic buzzerTwoEnable,
  input wire logic timerZeroSrcSel,
  input wire logic timerZeroLowclkSel,
  input wire logic timerOneSrcSel,
  input wire logic timerTwoSrcSel,
  input wire logic timerThreeSrcSel,
  // Events and derived signals
  output logic irqRequest,
  output logic levelChangeFlag,
  output logic [1:0] extIrqPulse,
  output logic extResetReq,
  output logic extClockTimer0,
  output logic extClockTimer1,
  output logic extClockTimer2,
  output logic extClockTimer3,
  output logic xtalMode
);

  // ==========================================================
  // Elaboration check
  if (ADDR_WIDTH < 8 || ADDR_WIDTH > 32) begin : g_chk
    $error("dual_port_io ADDR_WIDTH must be 8 to 32");
  end

  // ==========================================================
  // State
  typedef struct packed {
    logic [PA_PINS-1:0] dataA;
    logic [PB_PINS-1:0] dataB;
    logic [PA_PINS-1:0] dirA;
    logic [PB_PINS-1:0] dirB;
    logic [7:0] phA;
    logic [PB_PINS-1:0] phB;
    logic [7:0] plShared;
    logic [PB_PINS-1:0] odB;
    logic [7:0] powerCtrl;
    logic [PA_PINS-1:0] chgSelA;
    logic [PB_PINS-1:0] chgSelB;
    logic chgFlag;
    logic chgIe;
    logic global_irq_enable;
    logic [7:0] edgeReg;
    logic irEnable;
    logic [PIN_COUNT-1:0] readType;
    logic [PIN_COUNT-1:0] prevPins;
    logic [1:0] settle;
    logic awHeld;
    logic [ADDR_WIDTH-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [PIN_COUNT-1:0] padOut;
    logic [PIN_COUNT-1:0] padOe;
    logic [PIN_COUNT-1:0] padPullUp;
    logic [PIN_COUNT-1:0] padPullDown;
    logic irqReq;
    logic extRst;
    logic [1:0] extIrq;
    logic [3:0] tmrClk;
  } state_t;

  localparam state_t ST_RESET = '{
    dirA: DIR_A_RESET,
    dirB: DIR_B_RESET,
    default: '0
  };

  state_t s;
  state_t next_s;
  logic [PIN_COUNT-1:0] pins;

  // Edge test for the external interrupt pins
  function automatic logic edgeHit(logic prev, logic cur,
                                   logic [1:0] sel);
    logic rise;
    logic fall;
    rise = ~prev & cur;
    fall = prev & ~cur;
    case (sel)
      EDGE_RISING: edgeHit = rise;
      EDGE_FALLING: edgeHit = fall;
      default: edgeHit = rise | fall;
    endcase
  endfunction

  // ==========================================================
  // Pad input synchroniser
  sync_bits #(.WIDTH(PIN_COUNT)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .dIn(padIn),
    .qOut(pins)
  );

  // ==========================================================
  // Pad attribute vectors
  logic [PIN_COUNT-1:0] dirIn;
  logic [PIN_COUNT-1:0] latch;
  logic [PIN_COUNT-1:0] puVec;
  logic [PIN_COUNT-1:0] pdVec;
  logic [PIN_COUNT-1:0] odVec;
  logic [PIN_COUNT-1:0] ovrEn;
  logic [PIN_COUNT-1:0] ovrVal;
  logic [PIN_COUNT-1:0] padFree;
  logic [PIN_COUNT-1:0] readView;
  logic [PIN_COUNT-1:0] chgMask;
  logic settled;
  logic writeFire;

  assign dirIn = {s.dirB, s.dirA};
  assign latch = {s.dataB, s.dataA};
  // PA5 pull-high comes from power control
  assign puVec = {s.phB, s.phA[7:6], s.powerCtrl[PWR_PA5_PH_BIT],
                  s.phA[4:0]};
  assign pdVec = {2'h0, s.plShared[7:4], 2'h0, s.phA[PA5_PL_BIT],
                  1'h0, s.plShared[3:0]};
  // PA5 output is always open-drain
  assign odVec = {s.odB, 2'h0, 1'h1, 5'h00};
  assign readView = (s.readType & latch) |
                    (~s.readType & pins);
  // Ext interrupt pins drop out of level-change detect
  assign chgMask = {s.chgSelB & ~{4'h0, s.edgeReg[EXT1_SEL_BIT],
                    s.edgeReg[EXT0_SEL_BIT]},
                    s.chgSelA};
  assign settled = (s.settle == SETTLE_DONE);
  assign writeFire = s.awHeld & s.wHeld & ~s.bvalid;

  // Shared-function overrides and crystal release
  always_comb begin
    ovrEn = '0;
    ovrVal = '0;
    padFree = '0;
    // Comparator beats PWM one, PWM one beats buzzer one
    if (comparatorOutEnable) begin
      ovrEn[PIN_PB3] = 1'b1;
      ovrVal[PIN_PB3] = cmpOut;
    end else if (pwmOneOutEnable) begin
      ovrEn[PIN_PB3] = 1'b1;
      ovrVal[PIN_PB3] = pwmOne;
    end else if (buzzerOneEnable) begin
      ovrEn[PIN_PB3] = 1'b1;
      ovrVal[PIN_PB3] = buzzerOne;
    end
    if (pwmTwoOutEnable) begin
      ovrEn[PIN_PB2] = 1'b1;
      ovrVal[PIN_PB2] = pwmTwo;
    end else if (buzzerTwoEnable) begin
      ovrEn[PIN_PB2] = 1'b1;
      ovrVal[PIN_PB2] = buzzerTwo;
    end
    // Carrier pad depends on the current strap
    if (s.irEnable && cfgIrLargeCurrent) begin
      ovrEn[PIN_PA3] = 1'b1;
      ovrVal[PIN_PA3] = irCarrier;
    end else if (s.irEnable) begin
      ovrEn[PIN_PB1] = 1'b1;
      ovrVal[PIN_PB1] = irCarrier;
    end
    if (cfgCrystal) begin
      padFree[PIN_PA6] = 1'b1;
      padFree[PIN_PA7] = 1'b1;
    end else if (cfgClockOut) begin
      ovrEn[PIN_PA7] = 1'b1;
      ovrVal[PIN_PA7] = instrClk;
    end
    // A reset pin must never be driven by the port
    if (cfgExtReset) begin
      padFree[PIN_PA5] = 1'b1;
    end
  end

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic drive;
    logic val;
    logic chgSet;
    drive = 1'b0;
    val = 1'b0;
    chgSet = 1'b0;
    next_s = s;

    // Pad drive; pulls only while the pin is not driven
    for (int i = 0; i < PIN_COUNT; i++) begin
      drive = ~padFree[i] & (ovrEn[i] | ~dirIn[i]);
      val = ovrEn[i] ? ovrVal[i] : latch[i];
      if (drive && odVec[i] && !ovrEn[i]) begin
        next_s.padOut[i] = 1'b0;
        next_s.padOe[i] = ~val;
      end else begin
        next_s.padOut[i] = drive & val;
        next_s.padOe[i] = drive;
      end
      next_s.padPullUp[i] = ~drive & puVec[i] &
                            ~(padFree[i] & cfgCrystal);
      next_s.padPullDown[i] = ~drive & pdVec[i] &
                              ~(padFree[i] & cfgCrystal);
    end
    // Carrier inputs never reach a pad with infrared off
    if (!s.irEnable) begin
      next_s.padOut[PIN_PB1] = next_s.padOut[PIN_PB1] &
                               ~ovrEn[PIN_PB1];
    end

    // Level change; ignored until the synchroniser has filled
    next_s.prevPins = pins;
    next_s.settle = settled ? s.settle : 2'(s.settle + 2'h1);
    chgSet = settled & |((pins ^ s.prevPins) & chgMask);

    // External edge interrupts on PB0 and PB1
    next_s.extIrq[0] = settled & s.edgeReg[EXT0_SEL_BIT] &
      edgeHit(s.prevPins[PIN_PB0], pins[PIN_PB0],
              s.edgeReg[EDGE0_LSB +: 2]);
    next_s.extIrq[1] = settled & s.edgeReg[EXT1_SEL_BIT] &
      edgeHit(s.prevPins[PIN_PB1], pins[PIN_PB1],
              s.edgeReg[EDGE1_LSB +: 2]);

    // Reset pin and timer clock routing
    next_s.extRst = cfgExtReset & settled & ~pins[PIN_PA5];
    next_s.tmrClk[0] = timerZeroSrcSel & ~timerZeroLowclkSel &
                       pins[PIN_PA4];
    next_s.tmrClk[1] = timerOneSrcSel & pins[PIN_PA4];
    next_s.tmrClk[2] = timerTwoSrcSel & pins[PIN_PA1];
    next_s.tmrClk[3] = timerThreeSrcSel & pins[PIN_PA1];

    // Write address and data are taken in either order
    if (awvalid && awready) begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && wready) begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (writeFire) begin
      next_s.awHeld = 1'b0;
      next_s.wHeld = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      if (s.wStrb[0]) begin
        case (s.awAddr)
          ADDR_WIDTH'(OFS_DATA_A): next_s.dataA = s.wData[7:0];
          ADDR_WIDTH'(OFS_DATA_B): next_s.dataB = s.wData[5:0];
          ADDR_WIDTH'(OFS_DIR_A): next_s.dirA = s.wData[7:0];
          ADDR_WIDTH'(OFS_DIR_B): next_s.dirB = s.wData[5:0];
          ADDR_WIDTH'(OFS_PH_A): next_s.phA = s.wData[7:0];
          ADDR_WIDTH'(OFS_PH_B): next_s.phB = s.wData[5:0];
          ADDR_WIDTH'(OFS_PL_SHARED): next_s.plShared = s.wData[7:0];
          ADDR_WIDTH'(OFS_OD_B): next_s.odB = s.wData[5:0];
          ADDR_WIDTH'(OFS_POWER): next_s.powerCtrl = s.wData[7:0];
          ADDR_WIDTH'(OFS_CHG_A): next_s.chgSelA = s.wData[7:0];
          ADDR_WIDTH'(OFS_CHG_B): next_s.chgSelB = s.wData[5:0];
          ADDR_WIDTH'(OFS_IRQ_FLAG): begin
            // Only a written zero clears the flag
            if (!s.wData[FLAG_CHG_BIT]) begin
              next_s.chgFlag = 1'b0;
            end
          end
          ADDR_WIDTH'(OFS_IRQ_EN): next_s.chgIe = s.wData[IE_CHG_BIT];
          ADDR_WIDTH'(OFS_PROC): next_s.global_irq_enable = s.wData[GIE_BIT];
          ADDR_WIDTH'(OFS_EDGE): next_s.edgeReg = s.wData[7:0];
          ADDR_WIDTH'(OFS_IR): next_s.irEnable = s.wData[IR_EN_BIT];
          ADDR_WIDTH'(OFS_READ_TYPE): begin
            next_s.readType[7:0] = s.wData[7:0];
          end
          default: next_s.bresp = RESP_SLVERR;
        endcase
      end
      if (s.wStrb[1] && s.awAddr == ADDR_WIDTH'(OFS_READ_TYPE)) begin
        next_s.readType[13:8] = s.wData[13:8];
      end
    end
    // A hardware set in the clearing cycle wins
    if (chgSet) begin
      next_s.chgFlag = 1'b1;
    end
    next_s.irqReq = next_s.chgFlag & next_s.chgIe &
                    next_s.global_irq_enable;

    // Read port; unmapped addresses answer SLVERR
    if (rvalid && rready) begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      next_s.rdata = '0;
      case (araddr)
        ADDR_WIDTH'(OFS_DATA_A): next_s.rdata[7:0] = readView[7:0];
        ADDR_WIDTH'(OFS_DATA_B): next_s.rdata[5:0] = readView[13:8];
        ADDR_WIDTH'(OFS_DIR_A): next_s.rdata[7:0] = s.dirA;
        ADDR_WIDTH'(OFS_DIR_B): next_s.rdata[5:0] = s.dirB;
        ADDR_WIDTH'(OFS_PH_A): next_s.rdata[7:0] = s.phA;
        ADDR_WIDTH'(OFS_PH_B): next_s.rdata[5:0] = s.phB;
        ADDR_WIDTH'(OFS_PL_SHARED): next_s.rdata[7:0] = s.plShared;
        ADDR_WIDTH'(OFS_OD_B): next_s.rdata[5:0] = s.odB;
        ADDR_WIDTH'(OFS_POWER): next_s.rdata[7:0] = s.powerCtrl;
        ADDR_WIDTH'(OFS_CHG_A): next_s.rdata[7:0] = s.chgSelA;
        ADDR_WIDTH'(OFS_CHG_B): next_s.rdata[5:0] = s.chgSelB;
        ADDR_WIDTH'(OFS_IRQ_FLAG): begin
          next_s.rdata[FLAG_CHG_BIT] = s.chgFlag;
        end
        ADDR_WIDTH'(OFS_IRQ_EN): next_s.rdata[IE_CHG_BIT] = s.chgIe;
        ADDR_WIDTH'(OFS_PROC): next_s.rdata[GIE_BIT] = s.global_irq_enable;
        ADDR_WIDTH'(OFS_EDGE): next_s.rdata[7:0] = s.edgeReg;
        ADDR_WIDTH'(OFS_IR): next_s.rdata[IR_EN_BIT] = s.irEnable;
        ADDR_WIDTH'(OFS_READ_TYPE): begin
          next_s.rdata[13:0] = s.readType;
        end
        default: next_s.rresp = RESP_SLVERR;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= ST_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs
  // Ready drops while a response is pending: one write at a time
  assign awready = ~s.awHeld & ~s.bvalid;
  assign wready = ~s.wHeld & ~s.bvalid;
  assign arready = ~s.rvalid;
  assign bvalid = s.bvalid;
  assign bresp = s.bresp;
  assign rvalid = s.rvalid;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign padOut = s.padOut;
  assign padOe = s.padOe;
  assign padPullUp = s.padPullUp;
  assign padPullDown = s.padPullDown;
  assign irqRequest = s.irqReq;
  assign levelChangeFlag = s.chgFlag;
  assign extIrqPulse = s.extIrq;
  assign extResetReq = s.extRst;
  assign extClockTimer0 = s.tmrClk[0];
  assign extClockTimer1 = s.tmrClk[1];
  assign extClockTimer2 = s.tmrClk[2];
  assign extClockTimer3 = s.tmrClk[3];
  assign xtalMode = cfgCrystal; // Strap echo for the oscillator

endmodule

`default_nettype wire

// ---- testbench/dual_port_io_chk.sv ----
/* Checker for dual_port_io: pulls, flag, pin functions, straps.
   Bound to every dual_port_io instance; sees its ports only. */
`timescale 1ns/10ps
`default_nettype none
module dual_port_io_chk import gpio_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic bvalid,
  input wire logic [PIN_COUNT-1:0] padIn,
  input wire logic [PIN_COUNT-1:0] padOut,
  input wire logic [PIN_COUNT-1:0] padOe,
  input wire logic [PIN_COUNT-1:0] padPullUp,
  input wire logic [PIN_COUNT-1:0] padPullDown,
  input wire logic cfgExtReset,
  input wire logic cfgCrystal,
  input wire logic cmpOut,
  input wire logic comparatorOutEnable,
  input wire logic pwmTwo,
  input wire logic pwmTwoOutEnable,
  input wire logic buzzerTwo,
  input wire logic buzzerTwoEnable,
  input wire logic irqRequest,
  input wire logic levelChangeFlag,
  input wire logic extResetReq
);
  // ======
  // One clock domain, reset silences everything
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Pad drive and pulls
  a_no_pull_driven: assert property (
    (padOe & (padPullUp | padPullDown)) == '0)
    else $error("pull left on a driven pin");
  a_xtal_free: assert property (
    cfgCrystal |=> padOe[7:6] == 2'h0 && padPullUp[7:6] == 2'h0)
    else $error("crystal pins not released");
  // Flag clears only on a register write, seen as bvalid rising
  a_flag_sticky: assert property (
    $fell(levelChangeFlag) |-> $rose(bvalid))
    else $error("flag cleared without a write");
  a_irq_has_flag: assert property (
    irqRequest |-> levelChangeFlag)
    else $error("request without flag");
  // Shared functions reach the pad one edge after their source
  a_pb3_cmp: assert property (
    comparatorOutEnable |=> padOe[PIN_PB3]
      && padOut[PIN_PB3] == $past(cmpOut))
    else $error("comparator missing on PB3");
  a_pb2_pwm: assert property (
    pwmTwoOutEnable |=> padOut[PIN_PB2] == $past(pwmTwo))
    else $error("pwm two missing on PB2");
  a_pb2_buzzer: assert property (
    !pwmTwoOutEnable && buzzerTwoEnable
      |=> padOut[PIN_PB2] == $past(buzzerTwo))
    else $error("buzzer two missing on PB2");
  // Reset pin: never driven, low level asks for reset after sync
  a_pa5_undriven: assert property (
    cfgExtReset |=> !padOe[PIN_PA5])
    else $error("reset pin driven");
  a_pa5_reset: assert property (
    (cfgExtReset && !padIn[PIN_PA5]) [*4] |-> extResetReq)
    else $error("reset request missing");
  c_flag: cover property ($rose(levelChangeFlag));
  c_irq: cover property ($rose(irqRequest));
  c_reset: cover property ($rose(extResetReq));
endmodule
bind dual_port_io dual_port_io_chk chk (.*);
`default_nettype wire

// ---- testbench/pad_model.sv ----
/* Board side of the pads: block drive, board drive, resistors.
   Assumes the bench sets extDrive and extLevel per pin. */
`timescale 1ns/10ps
`default_nettype none
module pad_model import gpio_pkg::*; (
  input wire logic sys_clk,
  input wire logic [PIN_COUNT-1:0] padOut,
  input wire logic [PIN_COUNT-1:0] padOe,
  input wire logic [PIN_COUNT-1:0] padPullUp,
  input wire logic [PIN_COUNT-1:0] padPullDown,
  input wire logic [PIN_COUNT-1:0] extDrive,
  input wire logic [PIN_COUNT-1:0] extLevel,
  output logic [PIN_COUNT-1:0] padIn
);
  // Open pins wander so nothing leans on a stale level
  logic [PIN_COUNT-1:0] floatVal = '0;
  always @(posedge sys_clk) floatVal <= ~floatVal;
  // Block drive wins over board, board over resistors
  always_comb begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      if (padOe[i]) padIn[i] = padOut[i];
      else if (extDrive[i]) padIn[i] = extLevel[i];
      else if (padPullUp[i]) padIn[i] = 1'h1;
      else if (padPullDown[i]) padIn[i] = 1'h0;
      else padIn[i] = floatVal[i];
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dual_port_io_tb_top.sv ----
/* Self-checking bench for dual_port_io: bus master, straps, sources.
   Assumes pad_model on the pads and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module dual_port_io_tb_top import gpio_pkg::*;;
  logic sys_clk, rst_b, awvalid, awready, wvalid, wready, bvalid;
  logic bready, arvalid, arready, rvalid, rready, xtalMode;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rsp, extIrqPulse;
  logic [PIN_COUNT-1:0] padIn, padOut, padOe, padPullUp, padPullDown;
  logic [PIN_COUNT-1:0] extDrive, extLevel;
  logic cfgIrLargeCurrent, cfgExtReset, cfgCrystal, cfgClockOut;
  logic instrClk, irCarrier, cmpOut, comparatorOutEnable, pwmOne;
  logic pwmOneOutEnable, buzzerOne, buzzerOneEnable, pwmTwo;
  logic pwmTwoOutEnable, buzzerTwo, buzzerTwoEnable, timerZeroSrcSel;
  logic timerZeroLowclkSel, timerOneSrcSel, timerTwoSrcSel;
  logic timerThreeSrcSel, irqRequest, levelChangeFlag, extResetReq;
  logic extClockTimer0, extClockTimer1, extClockTimer2, extClockTimer3;
  int nErrors = 0, checks = 0;
  dual_port_io uut (.*);
  pad_model board (.*);
  // ======
  // Clock and watchdog; tests need about 260 cycles
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    nErrors++;
    conclude();
  end
  // ======
  // Common tasks
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      nErrors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d errors=%0d", checks, nErrors);
    if (nErrors == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Sample at the falling edge, where outputs have settled
  task automatic look(int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic rd(logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rdv = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  task automatic flip(int p);
    @(posedge sys_clk);
    extLevel[p] <= ~extLevel[p];
    look(6);
  endtask
  // Count edge pulses after a pin move
  task automatic edgeOn(int p, logic v, int b, int e);
    int n = 0;
    @(posedge sys_clk);
    extLevel[p] <= v;
    repeat (8) begin
      @(negedge sys_clk);
      n += extIrqPulse[b];
    end
    chk(n, e);
  endtask
  // ======
  // Scenarios
  task automatic t_pads();
    look(1);
    chk(padOe, 14'h0000);
    wr(OFS_PH_A, 32'hFF);
    wr(OFS_PH_B, 32'h30);
    wr(OFS_PL_SHARED, 32'hF3);
    look(1);
    chk(padPullUp, 14'h30DF);
    chk(padPullDown, 14'h0F23);
    wr(OFS_POWER, 32'h10);
    look(1);
    chk(padPullUp, 14'h30FF);
    wr(OFS_DIR_A, 32'h00);
    wr(OFS_DATA_A, 32'hA5);
    wr(OFS_DIR_B, 32'h00);
    wr(OFS_OD_B, 32'h03);
    wr(OFS_DATA_B, 32'h0F);
    look(1);
    chk(padOe, 14'h3CDF);
    chk(padOut, 14'h0C85);
    chk(padPullUp | padPullDown, 14'h0000);
    wr(OFS_DIR_A, 32'hFF);
    wr(OFS_DIR_B, 32'h3F);
  endtask
  task automatic t_read();
    @(posedge sys_clk);
    extLevel[7:0] <= 8'h3C;
    look(3);
    rd(OFS_DATA_A);
    chk(rdv, 32'h3C);
    chk(rsp, RESP_OKAY);
    wr(OFS_DATA_A, 32'h00, 4'h0);
    wr(OFS_READ_TYPE, 32'h3FFF);
    rd(OFS_DATA_A);
    chk(rdv, 32'hA5);
    wr(OFS_READ_TYPE, 32'h00);
    rd(8'h80);
    chk(rsp, RESP_SLVERR);
    wr(8'h80, 32'h00);
    chk(rsp, RESP_SLVERR);
  endtask
  task automatic t_change();
    wr(OFS_CHG_B, 32'h10);
    wr(OFS_IRQ_EN, 32'h02);
    wr(OFS_PROC, 32'h80);
    wr(OFS_IRQ_FLAG, 32'h00);
    flip(13);
    chk(levelChangeFlag, 1'h0);
    flip(12);
    chk({levelChangeFlag, irqRequest}, 2'h3);
    wr(OFS_IRQ_FLAG, 32'h02);
    look(1);
    chk(levelChangeFlag, 1'h1);
    wr(OFS_PROC, 32'h00);
    look(1);
    chk(irqRequest, 1'h0);
    wr(OFS_IRQ_FLAG, 32'h00);
    look(1);
    chk(levelChangeFlag, 1'h0);
    wr(OFS_CHG_B, 32'h00);
    wr(OFS_CHG_A, 32'h80);
    flip(7);
    chk(levelChangeFlag, 1'h1);
    wr(OFS_CHG_A, 32'h00);
  endtask
  task automatic t_extint();
    flip(9);
    wr(OFS_CHG_B, 32'h03);
    wr(OFS_EDGE, 32'h34);
    wr(OFS_IRQ_FLAG, 32'h00);
    edgeOn(8, 1'h1, 0, 1);
    edgeOn(8, 1'h0, 0, 0);
    edgeOn(9, 1'h0, 1, 1);
    chk(levelChangeFlag, 1'h0);
    wr(OFS_EDGE, 32'h00);
    edgeOn(8, 1'h1, 0, 0);
    chk(levelChangeFlag, 1'h1);
    wr(OFS_CHG_B, 32'h00);
  endtask
  task automatic t_ir();
    @(posedge sys_clk);
    irCarrier <= 1'h1;
    wr(OFS_IR, 32'h01);
    look(1);
    chk({padOe[PIN_PB1], padOut[PIN_PB1], padOe[PIN_PA3]}, 3'h6);
    @(posedge sys_clk);
    cfgIrLargeCurrent <= 1'h1;
    look(2);
    chk({padOe[PIN_PA3], padOut[PIN_PA3], padOe[PIN_PB1]}, 3'h6);
    wr(OFS_IR, 32'h00);
    look(1);
    chk(padOe, 14'h0000);
  endtask
  task automatic t_func();
    @(posedge sys_clk);
    {cmpOut, pwmOne, buzzerOne, pwmTwo, buzzerTwo} <= 5'h15;
    {comparatorOutEnable, pwmOneOutEnable, buzzerOneEnable} <= 3'h7;
    {pwmTwoOutEnable, buzzerTwoEnable} <= 2'h3;
    look(2);
    chk(padOut[11:10], 2'h2);
    @(posedge sys_clk);
    comparatorOutEnable <= 1'h0;
    pwmTwoOutEnable <= 1'h0;
    look(2);
    chk(padOut[11:10], 2'h1);
    @(posedge sys_clk);
    pwmOneOutEnable <= 1'h0;
    buzzerTwoEnable <= 1'h0;
    look(2);
    chk({padOe[11:10], padOut[11]}, 3'h5);
  endtask
  task automatic t_straps();
    @(posedge sys_clk);
    cfgCrystal <= 1'h1;
    look(2);
    chk({padOe[7:6], padPullUp[7:6], xtalMode}, 5'h01);
    @(posedge sys_clk);
    cfgCrystal <= 1'h0;
    cfgClockOut <= 1'h1;
    instrClk <= 1'h1;
    look(2);
    chk({padOe[PIN_PA7], padOut[PIN_PA7]}, 2'h3);
    @(posedge sys_clk);
    instrClk <= 1'h0;
    cfgExtReset <= 1'h1;
    extLevel[5] <= 1'h0;
    {extLevel[4], extLevel[1]} <= 2'h3;
    {timerZeroSrcSel, timerOneSrcSel} <= 2'h3;
    {timerTwoSrcSel, timerThreeSrcSel} <= 2'h3;
    look(5);
    chk(padOut[PIN_PA7], 1'h0);
    chk(extResetReq, 1'h1);
    chk({extClockTimer0, extClockTimer1}, 2'h3);
    chk({extClockTimer2, extClockTimer3}, 2'h3);
    @(posedge sys_clk);
    timerZeroLowclkSel <= 1'h1;
    extLevel[5] <= 1'h1;
    look(5);
    chk({extClockTimer0, extClockTimer1}, 2'h1);
    chk(extResetReq, 1'h0);
  endtask
  // ======
  // Main sequence
  initial begin
    rst_b = 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {cfgIrLargeCurrent, cfgExtReset, cfgCrystal, cfgClockOut} = '0;
    {instrClk, irCarrier, cmpOut, pwmOne, buzzerOne, pwmTwo} = '0;
    {buzzerTwo, comparatorOutEnable, pwmOneOutEnable} = '0;
    {buzzerOneEnable, pwmTwoOutEnable, buzzerTwoEnable} = '0;
    {timerZeroSrcSel, timerZeroLowclkSel, timerOneSrcSel} = '0;
    {timerTwoSrcSel, timerThreeSrcSel} = '0;
    extDrive = '1;
    extLevel = '0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'h1;
    t_pads();
    t_read();
    t_change();
    t_extint();
    t_ir();
    t_func();
    t_straps();
    conclude();
  end
endmodule
`default_nettype wire
